// ==== design/sas_pkg.sv ====
package sas_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_RESH = 8'h0c;
  localparam logic [7:0] OFS_RESL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam int EN_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int JUST_BIT = 7;
  localparam logic [7:0] CTRL_WMASK = 8'h3d;
  localparam logic [7:0] PORT_WMASK = 8'h3f;
  localparam logic [7:0] TIME_WMASK = 8'hbf;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] CONV_LAST = 5'h0a;
  localparam logic [4:0] GAP_LAST = 5'h01;
  localparam logic [6:0] INSTR_TOSC = 7'h04;
  localparam logic [6:0] INSTR_LAST = INSTR_TOSC - 7'h01;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [4:0] NUM_PINS = 5'h10;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_ACQ = 5'b00100,
    ST_CONV = 5'b01000,
    ST_GAP = 5'b10000
  } sas_state_t;

  typedef struct packed {
    logic enable;
    logic sample;
    logic [3:0] channel;
    logic [1:0] vref;
    logic [9:0] trial;
  } sas_afe_t;

  function automatic logic [6:0] div_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: div_cycles = 7'h02;
      3'h4: div_cycles = 7'h04;
      3'h1: div_cycles = 7'h08;
      3'h5: div_cycles = 7'h10;
      3'h2: div_cycles = 7'h20;
      3'h6: div_cycles = 7'h40;
      default: div_cycles = 7'h02;
    endcase
  endfunction

  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    unique case (code)
      3'h0: acq_periods = 5'h00;
      3'h1: acq_periods = 5'h02;
      3'h2: acq_periods = 5'h04;
      3'h3: acq_periods = 5'h06;
      3'h4: acq_periods = 5'h08;
      3'h5: acq_periods = 5'h0c;
      3'h6: acq_periods = 5'h10;
      3'h7: acq_periods = 5'h14;
    endcase
  endfunction
endpackage

// ==== design/sas_sequencer.sv ====
`timescale 1ns/10ps
module sas_sequencer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock source and power state
  input wire logic rc_clk_i,
  input wire logic sleep_i,
  // analog front end
  input wire logic comp_i,
  output sas_pkg::sas_afe_t afe_o,
  output logic [15:0] pin_analog_o,
  // completion flag
  output logic done_flag_o
);
  logic [7:0] ctrl_q;
  logic [7:0] port_q;
  logic [7:0] time_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic go_q;
  logic go_d;
  logic done_q;
  logic done_d;
  logic ack_q;
  logic [31:0] dat_q;
  sas_pkg::sas_state_t state_q;
  sas_pkg::sas_state_t state_d;
  logic [4:0] per_q;
  logic [4:0] per_d;
  logic [6:0] cyc_q;
  logic [6:0] cyc_d;
  logic [9:0] sar_q;
  logic [9:0] sar_d;
  logic [3:0] bidx;
  logic finish;
  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_commit = req & wb_we_i & ack_q & wb_sel_i[0];
  wire wr_ctrl = wr_commit & (wb_adr_i == sas_pkg::OFS_CTRL);
  wire wr_port = wr_commit & (wb_adr_i == sas_pkg::OFS_PORT);
  wire wr_time = wr_commit & (wb_adr_i == sas_pkg::OFS_TIME);
  wire wr_stat = wr_commit & (wb_adr_i == sas_pkg::OFS_STAT);
  wire ctrl_en = ctrl_q[sas_pkg::EN_BIT];
  wire use_rc = time_q[1:0] == 2'b11;
  wire [6:0] div_len = sas_pkg::div_cycles(time_q[2:0]);
  wire [4:0] acq_len = sas_pkg::acq_periods(time_q[5:3]);
  wire [7:0] ctrl_rd = ctrl_q | {6'h00, go_q & ctrl_en, 1'b0};
  wire [7:0] rd_byte =
    (wb_adr_i == sas_pkg::OFS_CTRL) ? ctrl_rd :
    (wb_adr_i == sas_pkg::OFS_PORT) ? port_q :
    (wb_adr_i == sas_pkg::OFS_TIME) ? time_q :
    (wb_adr_i == sas_pkg::OFS_RESH) ? res_hi_q :
    (wb_adr_i == sas_pkg::OFS_RESL) ? res_lo_q :
    (wb_adr_i == sas_pkg::OFS_STAT) ? {7'h00, done_q} : 8'h00;

  // bit period timing
  wire running = (state_q == sas_pkg::ST_ACQ) | (state_q == sas_pkg::ST_CONV) |
    (state_q == sas_pkg::ST_GAP);
  // oscillator periods stall in sleep, the rc clock keeps going
  wire osc_hold = sleep_i & ~use_rc;
  wire osc_tick = running & ~osc_hold & (cyc_q == div_len - 7'h01);
  wire rc_rise = rc_s2_q & ~rc_s3_q;
  wire tick = running & (use_rc ? rc_rise : osc_tick);
  wire delay_done = (state_q == sas_pkg::ST_DELAY) & (cyc_q == sas_pkg::INSTR_LAST);
  wire set_go = wr_ctrl & wb_dat_i[sas_pkg::GO_BIT] & wb_dat_i[sas_pkg::EN_BIT];
  wire [9:0] res_val = sar_d;

  // rc clock is only a level here, so it passes two flops first
  always_ff @(posedge clk_i)
  begin
    rc_s1_q <= rc_clk_i;
    rc_s2_q <= rc_s1_q;
    rc_s3_q <= rc_s2_q;
  end

  always_comb
  begin
    state_d = state_q;
    per_d = per_q;
    finish = 1'b0;
    if (!ctrl_en)
    begin
      state_d = sas_pkg::ST_IDLE;
      per_d = 5'h00;
    end
    else
    begin
      unique case (state_q)
        sas_pkg::ST_IDLE:
          if (go_q)
          begin
            per_d = 5'h00;
            if (use_rc)
              state_d = sas_pkg::ST_DELAY;
            else if (acq_len == 5'h00)
              state_d = sas_pkg::ST_CONV;
            else
              state_d = sas_pkg::ST_ACQ;
          end
        sas_pkg::ST_DELAY:
          if (delay_done)
            state_d = (acq_len == 5'h00) ? sas_pkg::ST_CONV : sas_pkg::ST_ACQ;
        sas_pkg::ST_ACQ:
          if (tick)
          begin
            if (per_q == acq_len - 5'h01)
            begin
              state_d = sas_pkg::ST_CONV;
              per_d = 5'h00;
            end
            else
              per_d = per_q + 5'h01;
          end
        sas_pkg::ST_CONV:
          if (tick)
          begin
            if (per_q == sas_pkg::CONV_LAST)
            begin
              state_d = sas_pkg::ST_GAP;
              per_d = 5'h00;
              finish = 1'b1;
            end
            else
              per_d = per_q + 5'h01;
          end
        sas_pkg::ST_GAP:
          if (tick)
          begin
            if (per_q == sas_pkg::GAP_LAST)
            begin
              state_d = sas_pkg::ST_IDLE;
              per_d = 5'h00;
            end
            else
              per_d = per_q + 5'h01;
          end
      endcase
    end
  end

  // divider restarts on every state change so each phase starts aligned
  always_comb
  begin
    cyc_d = cyc_q + 7'h01;
    if (state_d != state_q || !(running || state_q == sas_pkg::ST_DELAY))
      cyc_d = 7'h00;
    else if (osc_tick)
      cyc_d = 7'h00;
    else if (osc_hold && running)
      cyc_d = cyc_q;
  end

  // first period sets the msb trial, each later one resolves a bit
  assign bidx = 4'(4'ha - per_q[3:0]);
  always_comb
  begin
    sar_d = sar_q;
    if (state_q == sas_pkg::ST_CONV && tick)
    begin
      if (per_q == 5'h00)
        sar_d = sas_pkg::SAR_MSB;
      else
      begin
        if (!comp_i)
          sar_d[bidx] = 1'b0;
        if (bidx != 4'h0)
          sar_d[bidx - 4'h1] = 1'b1;
      end
    end
  end

  assign go_d = (set_go | (go_q & ~finish)) & ~(wr_ctrl & ~wb_dat_i[sas_pkg::EN_BIT]);
  assign done_d = finish | (done_q & ~(wr_stat & wb_dat_i[0]));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= sas_pkg::REG_RESET;
      port_q <= sas_pkg::REG_RESET;
      time_q <= sas_pkg::REG_RESET;
      go_q <= 1'b0;
      done_q <= 1'b0;
      state_q <= sas_pkg::ST_IDLE;
      per_q <= 5'h00;
      cyc_q <= 7'h00;
      sar_q <= 10'h000;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= wb_dat_i[7:0] & sas_pkg::CTRL_WMASK;
      if (wr_port)
        port_q <= wb_dat_i[7:0] & sas_pkg::PORT_WMASK;
      if (wr_time)
        time_q <= wb_dat_i[7:0] & sas_pkg::TIME_WMASK;
      go_q <= go_d;
      done_q <= done_d;
      state_q <= state_d;
      per_q <= per_d;
      cyc_q <= cyc_d;
      sar_q <= sar_d;
      ack_q <= req & ~ack_q;
      if (req && !ack_q)
        dat_q <= {24'h00_0000, rd_byte};
    end
  end

  // result keeps its content through any reset
  always_ff @(posedge clk_i)
  begin
    if (finish && !rst_i)
    begin
      res_hi_q <= time_q[sas_pkg::JUST_BIT] ? {6'h00, res_val[9:8]} : res_val[9:2];
      res_lo_q <= time_q[sas_pkg::JUST_BIT] ? res_val[7:0] : {res_val[1:0], 6'h00};
    end
  end

  // code one already frees the top two pins, so only code zero keeps all sixteen
  wire [4:0] analog_cnt = (port_q[3:0] == 4'h0) ? sas_pkg::NUM_PINS :
    sas_pkg::NUM_PINS - 5'h01 - {1'b0, port_q[3:0]};
  wire [15:0] pin_an;
  for (genvar i = 0; i < 16; i++)
  begin : g_pin
    assign pin_an[i] = 5'(i) < analog_cnt;
  end
  assign pin_analog_o = pin_an;

  assign afe_o = '{
    enable: ctrl_en,
    sample: ctrl_en & (state_q != sas_pkg::ST_CONV),
    channel: ctrl_q[5:2],
    vref: port_q[5:4],
    trial: sar_q
  };
  assign done_flag_o = done_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // checks
  logic [4:0] conv_ticks_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != sas_pkg::ST_CONV)
      conv_ticks_q <= 5'h00;
    else if (tick)
      conv_ticks_q <= conv_ticks_q + 5'h01;
  end

  logic [4:0] acq_ticks_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != sas_pkg::ST_ACQ)
      acq_ticks_q <= 5'h00;
    else if (tick)
      acq_ticks_q <= acq_ticks_q + 5'h01;
  end

  // frozen cycles in sleep do not count
  logic [9:0] conv_cyc_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != sas_pkg::ST_CONV)
      conv_cyc_q <= 10'h000;
    else if (!osc_hold)
      conv_cyc_q <= conv_cyc_q + 10'h001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rc_start;
    state_q == sas_pkg::ST_IDLE && go_q && ctrl_en && use_rc;
  endsequence
  sequence s_delay_then_leave;
    (state_q == sas_pkg::ST_DELAY)[*4] ##1 (state_q != sas_pkg::ST_DELAY);
  endsequence
  sequence s_acq_leave;
    state_q == sas_pkg::ST_ACQ ##1 state_q == sas_pkg::ST_CONV;
  endsequence

  chk_finish_flags: assert property (finish |=> !go_q && done_q)
    else $error("go not cleared or done not set at completion");
  chk_off_idle: assert property (!ctrl_en && !set_go |=>
    state_q == sas_pkg::ST_IDLE && !go_q)
    else $error("converter active while disabled");
  chk_go_gated: assert property (wr_ctrl && !wb_dat_i[0] |=> !ctrl_rd[1] && !go_q)
    else $error("go reads busy while disabled");
  chk_pin_split: assert property ($countones(pin_analog_o) ==
    ((port_q[3:0] == 4'h0) ? 16 : 15 - int'(port_q[3:0])))
    else $error("analog pin count wrong");
  chk_gap_held: assert property (finish |=> (state_q == sas_pkg::ST_GAP)[*2])
    else $error("gap after conversion too short");
  chk_acq_skip: assert property (state_q == sas_pkg::ST_IDLE && go_q && ctrl_en && !use_rc
    && acq_len == 5'h00 |=> state_q == sas_pkg::ST_CONV)
    else $error("zero acquisition did not convert at once");
  chk_rc_delay: assert property (disable iff (rst_i || !ctrl_en)
    s_rc_start |=> s_delay_then_leave)
    else $error("rc start delay not four cycles");
  chk_conv_length: assert property (finish |-> conv_ticks_q == 5'h0a && tick)
    else $error("conversion not eleven bit periods");
  chk_sleep_hold: assert property (state_q == sas_pkg::ST_CONV && osc_hold
    && !wr_time |=> $stable(sar_q))
    else $error("oscillator conversion advanced in sleep");
  chk_reset_off: assert property (disable iff (1'b0)
    rst_i |=> !ctrl_q[0] && state_q == sas_pkg::ST_IDLE && !go_q)
    else $error("reset left converter running");
  chk_right_just: assert property (finish && time_q[7] |=> res_hi_q[7:2] == 6'h00)
    else $error("right justified high byte not zero filled");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_wait: assert property (req && !ack_q |=> wb_ack_o)
    else $error("request not acknowledged after one wait");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("unused read data bits not zero");
  chk_unimpl_zero: assert property (ctrl_rd[7:6] == 2'b00 && port_q[7:6] == 2'b00
    && !time_q[6])
    else $error("unimplemented bit reads one");
  chk_done_sticky: assert property (done_q && !(wr_stat && wb_dat_i[0]) |=> done_q)
    else $error("done flag lost without a clear");
  chk_go_start: assert property (state_q == sas_pkg::ST_IDLE && go_q && ctrl_en
    |=> state_q != sas_pkg::ST_IDLE)
    else $error("go set but sequencer stayed idle");
  chk_sample_back: assert property (finish && !wr_ctrl |=> afe_o.sample)
    else $error("sampling not resumed after conversion");
  chk_trial_msb: assert property (state_q == sas_pkg::ST_CONV && tick
    && per_q == 5'h00 |=> afe_o.trial == sas_pkg::SAR_MSB)
    else $error("first trial is not the msb");
  chk_acq_length: assert property (s_acq_leave |->
    $past(acq_ticks_q) == $past(acq_len) - 5'h01)
    else $error("acquisition period count wrong");
  chk_gap_exit: assert property (state_q == sas_pkg::ST_GAP |=>
    state_q == sas_pkg::ST_GAP || state_q == sas_pkg::ST_IDLE)
    else $error("acquisition started inside the gap");
  chk_osc_span: assert property (finish && !use_rc |-> int'(conv_cyc_q) ==
    (int'(sas_pkg::CONV_LAST) + 1) * int'(div_len) - 1)
    else $error("oscillator conversion length wrong");
endmodule

// ==== dv/sas_afe_model.sv ====
`timescale 1ns/10ps
module sas_afe_model (
  // clock
  input wire logic clk_i,
  // converter side
  input wire sas_pkg::sas_afe_t afe_i,
  input wire logic [9:0] base_i,
  output logic comp_o
);
  logic [9:0] held_q;
  logic tog_q = 1'b0;
  // channel n sits at base plus n*64, so a wrong channel shows in the result
  always_ff @(posedge clk_i)
  begin
    tog_q <= ~tog_q;
    if (afe_i.enable && afe_i.sample)
      held_q <= base_i + {afe_i.channel, 6'h00};
  end
  // powered down: no valid decision, so the line toggles instead of holding
  assign comp_o = afe_i.enable ? (held_q >= afe_i.trial) : tog_q;
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic clk_i, rst_i, rc_clk, sleep, cyc, stb, we, ack, done, comp;
  logic [7:0] adr, rd, last_hi;
  logic [31:0] wdat, rdat;
  logic [15:0] pins;
  logic [3:0] sel;
  logic [9:0] base, v;
  sas_pkg::sas_afe_t afe;
  int bad_count, num_checks, t0, cy;
  int tick = 0;
  typedef struct packed {
    logic [7:0] tm;
    logic [3:0] ch;
    logic [9:0] b;
    logic [4:0] a;
    logic [6:0] d;
    logic sl;
  } sas_row_t;
  sas_row_t rows [8];

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // rc source free-running, phase unrelated to clk_i
  initial
  begin
    rc_clk = 1'b0;
    forever #23 rc_clk = ~rc_clk;
  end
  always @(posedge clk_i) tick <= tick + 1;

  sas_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rc_clk_i(rc_clk), .sleep_i(sleep), .comp_i(comp), .afe_o(afe),
    .pin_analog_o(pins), .done_flag_o(done));
  sas_afe_model u_afe (.clk_i(clk_i), .afe_i(afe), .base_i(base), .comp_o(comp));

  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    rd = rdat[7:0];
    if (n >= 40)
    begin
      bad_count++;
      wrap_up;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000)
    begin
      bad_count++;
      wrap_up;
    end
  endtask

  initial
  begin
    {rst_i, cyc, stb, we, sleep, adr, wdat, base} = {5'h10, 8'h00, 32'h0, 10'h0};
    {bad_count, num_checks} = 0;
    sel = 4'h1;
    rows = '{'{8'h80, 4'h3, 10'h015, 5'd0, 7'd2, 1'b0}, '{8'h0c, 4'hf, 10'h2a7, 5'd2, 7'd4, 1'b0},
      '{8'h91, 4'h7, 10'h100, 5'd4, 7'd8, 1'b0}, '{8'h1d, 4'h0, 10'h3ff, 5'd6, 7'd16, 1'b0},
      '{8'ha2, 4'hc, 10'h001, 5'd8, 7'd32, 1'b0}, '{8'h2e, 4'h9, 10'h155, 5'd12, 7'd64, 1'b0},
      '{8'hb3, 4'h5, 10'h0aa, 5'd16, 7'd0, 1'b1}, '{8'h3f, 4'ha, 10'h2d2, 5'd20, 7'd0, 1'b0}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, sas_pkg::OFS_TIME, 8'h00);
    chk("time", 0, rd);
    chk("pins", 32'hffff, pins);
    bus(1, sas_pkg::OFS_TIME, 8'hff);
    bus(0, sas_pkg::OFS_TIME, 8'h00);
    chk("time", 8'hbf, rd);
    // write without byte lane zero is acked but must not land
    sel <= 4'h0;
    bus(1, sas_pkg::OFS_TIME, 8'h00);
    sel <= 4'h1;
    bus(0, sas_pkg::OFS_TIME, 8'h00);
    chk("time_sel", 8'hbf, rd);
    bus(1, sas_pkg::OFS_CTRL, 8'hfe);
    bus(0, sas_pkg::OFS_CTRL, 8'h00);
    chk("ctrl", 8'h3c, rd);
    chk("enable", 0, afe.enable);
    bus(0, 8'h1c, 8'h00);
    chk("unmapped", 0, rd);
    for (int k = 0; k < 16; k++)
    begin
      bus(1, sas_pkg::OFS_PORT, 8'hc0 | 8'(k) | 8'((k % 4) << 4));
      bus(0, sas_pkg::OFS_PORT, 8'h00);
      chk("port", 8'(k) | 8'((k % 4) << 4), rd);
      chk("pins", (k == 0) ? 32'hffff : (32'h1 << (15 - k)) - 1, pins);
      chk("vref", k % 4, afe.vref);
    end
    foreach (rows[i])
    begin
      base <= rows[i].b;
      sleep <= rows[i].sl;
      bus(1, sas_pkg::OFS_TIME, rows[i].tm);
      bus(1, sas_pkg::OFS_CTRL, {2'b00, rows[i].ch, 2'b01});
      bus(1, sas_pkg::OFS_CTRL, {2'b00, rows[i].ch, 2'b11});
      t0 = tick;
      bus(0, sas_pkg::OFS_CTRL, 8'h00);
      chk("go", 1, rd[1]);
      chk("chan", rows[i].ch, afe.channel);
      wait_done;
      cy = (rows[i].a + 11) * rows[i].d;
      if (cy != 0)
        chk("span", 1, tick - t0 >= cy && tick - t0 <= cy + 8);
      v = rows[i].b + {rows[i].ch, 6'h00};
      bus(0, sas_pkg::OFS_CTRL, 8'h00);
      chk("idle", {2'b00, rows[i].ch, 2'b01}, rd);
      chk("sample", 1, afe.sample);
      bus(0, sas_pkg::OFS_RESH, 8'h00);
      last_hi = rd;
      chk("res_hi", rows[i].tm[7] ? {6'h00, v[9:8]} : v[9:2], rd);
      bus(0, sas_pkg::OFS_RESL, 8'h00);
      chk("res_lo", rows[i].tm[7] ? v[7:0] : {v[1:0], 6'h00}, rd);
      bus(1, sas_pkg::OFS_STAT, 8'h01);
      bus(0, sas_pkg::OFS_STAT, 8'h00);
      chk("clear", 0, rd);
      sleep <= 1'b0;
      // software side keeps the two-period gap before the next go
      repeat (2 * rows[i].d + 40) @(posedge clk_i);
    end
    // oscillator clock in sleep: conversion stalls until wake
    bus(1, sas_pkg::OFS_TIME, 8'h00);
    sleep <= 1'b1;
    bus(1, sas_pkg::OFS_CTRL, 8'h03);
    repeat (200) @(posedge clk_i);
    bus(0, sas_pkg::OFS_CTRL, 8'h00);
    chk("sleep_go", 8'h03, rd);
    chk("sleep_done", 0, done);
    sleep <= 1'b0;
    wait_done;
    v = base;
    bus(0, sas_pkg::OFS_RESH, 8'h00);
    last_hi = rd;
    chk("res_hi", v[9:2], rd);
    bus(1, sas_pkg::OFS_STAT, 8'h01);
    // reset in mid-acquisition aborts but keeps the result
    bus(1, sas_pkg::OFS_TIME, 8'h2e);
    bus(1, sas_pkg::OFS_CTRL, 8'h03);
    repeat (100) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, sas_pkg::OFS_CTRL, 8'h00);
    chk("ctrl", 0, rd);
    bus(0, sas_pkg::OFS_RESH, 8'h00);
    chk("res_hi", last_hi, rd);
    repeat (2000) @(posedge clk_i);
    chk("done", 0, done);
    wrap_up;
  end
endmodule
